// file: hw/scm_core.sv
// sensor correction datapath with measurement command handling
//
// Behaviour
// RQ1: A2 with zero data converts sensor using primary setup word at 12.
// RQ2: A3 and A7 use the host-supplied 16-bit setup word for one conversion.
// RQ3: temperature with host setup word ignores bits 15 to 12.
// RQ4: A6 converts temperature using internal factory temperature setup word.
// RQ5: primary setup is active by default and after any reset.
// RQ6: B1 activates alternate setup at 16, B0 activates primary; host repeats after reset.
// RQ7: AA to AF return corrected results from stored coefficients.
// RQ8: alternate setup without correction passes raw auto-zeroed value unchanged.
// RQ9: saturated intermediate still yields a result and sets status bit 0.
// RQ10: each bounded step clamps to its limits and records saturation.
// RQ11: shape select 0 picks parabolic, otherwise S-shaped compensation.
// RQ12: integer arithmetic; corrected output unsigned 0 to FFFFFF.
// RQ13: raw inputs are signed auto-zeroed values within plus or minus 7FFFF.
// RQ14: K1 from temperature gain terms, stages clamped to plus or minus 2^25.
// RQ15: K2 from offsets, raw sensor and temperature terms, stages clamped.
// RQ16: Zsp from sensor gain times clamped K1 K2 product, clamped 0 to 2^25-1.
// RQ17: parabolic output from Zsp and curvature, clamped 0 to 2^24-1.
// RQ18: host keeps post offsets zero during initial calibration.
// RQ19: host collects at least seven measurement pairs over three temperatures.
// RQ20: evaluate K1 K2, Zsp, output in order, latch with status, pulse done.
`timescale 1ns/10ps
module scm_core (
  mclk,
  rstn,
  external_reset_pin_n,
  cmd_valid,
  cmd_code,
  cmd_data,
  cmd_ready,
  primary_setup_word,
  alternate_setup_word,
  temp_factory_setup,
  coef,
  conv_start,
  conv_is_temp,
  conv_setup,
  conv_done,
  raw_sensor,
  raw_temp,
  alt_active,
  result,
  result_valid
);
  import scm_pkg::*;
  input wire logic mclk;
  input wire logic rstn;
  input wire logic external_reset_pin_n;
  input wire logic cmd_valid;
  input wire logic [7:0] cmd_code;
  input wire logic [15:0] cmd_data;
  output logic cmd_ready;
  input wire logic [15:0] primary_setup_word;
  input wire logic [15:0] alternate_setup_word;
  input wire logic [15:0] temp_factory_setup;
  input wire scm_pkg::scm_coef_t coef;
  output logic conv_start;
  output logic conv_is_temp;
  output logic [15:0] conv_setup;
  input wire logic conv_done;
  input wire logic signed [23:0] raw_sensor;
  input wire logic signed [23:0] raw_temp;
  output logic alt_active;
  output scm_pkg::scm_result_t result;
  output logic result_valid;

  // ==========================================================
  // reset pin synchroniser
  // pin is asynchronous; only the second flop may read the first
  logic pin_s1_q;
  logic pin_s2_q;
  always_ff @(posedge mclk) begin
    pin_s1_q <= external_reset_pin_n;
    pin_s2_q <= pin_s1_q;
  end
  logic rst_int;
  assign rst_int = !rstn || !pin_s2_q;

  // ==========================================================
  // clamp helper
  // flag returned per call so every stage reports its own overflow
  function automatic logic signed [W-1:0] clampv(input logic signed [W-1:0] v,
      input logic signed [W-1:0] lo, input logic signed [W-1:0] hi, output logic sat);
    begin
      sat = 1'b0;
      clampv = v;
      if (v < lo) begin
        clampv = lo;
        sat = 1'b1;
      end else if (v > hi) begin
        clampv = hi;
        sat = 1'b1;
      end
    end
  endfunction : clampv

  function automatic logic signed [W-1:0] sx(input logic signed [23:0] v);
    sx = {{(W-24){v[23]}}, v};
  endfunction : sx

  function automatic logic signed [W-1:0] mulsh(input logic signed [W-1:0] a,
      input logic signed [W-1:0] b, input int sh);
    logic signed [2*W-1:0] p;
    begin
      p = a * b;
      mulsh = W'(p >>> sh);
    end
  endfunction : mulsh

  // corrected-measurement range, shared by decode and result routing
  function automatic logic is_corr(input logic [7:0] code);
    is_corr = (code >= CMD_CORR_FIRST) && (code <= CMD_CORR_LAST);
  endfunction : is_corr

  // ==========================================================
  // state machine
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_CONV = 6'b000010,
    ST_K = 6'b000100,
    ST_ZSP = 6'b001000,
    ST_OUT = 6'b010000,
    ST_DONE = 6'b100000
  } scm_state_t;
  scm_state_t state_q;
  logic corr_q;
  logic temp_q;
  logic sat_q;
  logic signed [W-1:0] k1_q;
  logic signed [W-1:0] k2_q;
  logic signed [W-1:0] zsp_q;
  logic signed [W-1:0] rs_q;
  logic signed [W-1:0] rt_q;

  assign cmd_ready = (state_q == ST_IDLE);
  logic take;
  assign take = cmd_valid && cmd_ready;
  logic is_meas;
  assign is_meas = (cmd_code == CMD_RAW_S_STORED) || (cmd_code == CMD_RAW_S_USER) ||
                   (cmd_code == CMD_RAW_T_STORED) || (cmd_code == CMD_RAW_T_USER) ||
                   is_corr(cmd_code);

  // active setup select
  // pin reset also clears it, so the host must resend the select
  always_ff @(posedge mclk) begin
    if (rst_int) begin
      alt_active <= 1'b0; // RQ5
    end else if (take && cmd_code == CMD_SEL_ALT) begin
      alt_active <= 1'b1; // RQ6
    end else if (take && cmd_code == CMD_SEL_PRIMARY) begin
      alt_active <= 1'b0; // RQ6
    end
  end

  // conversion request
  // setup copied at take time; later input changes miss this conversion
  always_ff @(posedge mclk) begin
    if (rst_int) begin
      conv_start <= 1'b0;
      conv_is_temp <= 1'b0;
      conv_setup <= 16'h0000;
      corr_q <= 1'b0;
      temp_q <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      if (take && is_meas) begin
        conv_start <= 1'b1;
        corr_q <= is_corr(cmd_code); // RQ7
        if (cmd_code == CMD_RAW_S_STORED) begin
          conv_is_temp <= 1'b0;
          conv_setup <= primary_setup_word; // RQ1
          temp_q <= 1'b0;
        end else if (cmd_code == CMD_RAW_S_USER) begin
          conv_is_temp <= 1'b0;
          conv_setup <= cmd_data; // RQ2
          temp_q <= 1'b0;
        end else if (cmd_code == CMD_RAW_T_STORED) begin
          conv_is_temp <= 1'b1;
          conv_setup <= temp_factory_setup; // RQ4
          temp_q <= 1'b1;
        end else if (cmd_code == CMD_RAW_T_USER) begin
          conv_is_temp <= 1'b1;
          conv_setup <= cmd_data & TEMP_SETUP_MASK; // RQ2 RQ3
          temp_q <= 1'b1;
        end else begin
          conv_is_temp <= 1'b0;
          conv_setup <= alt_active ? alternate_setup_word : primary_setup_word;
          temp_q <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // datapath stages
  logic signed [W-1:0] k1_d;
  logic signed [W-1:0] k2_d;
  logic signed [W-1:0] zsp_d;
  logic signed [W-1:0] out_d;
  logic sat_k;
  logic sat_z;
  logic sat_o;
  always_comb begin
    logic signed [W-1:0] a;
    logic signed [W-1:0] tr;
    logic s0;
    logic s1;
    logic s2;
    logic s3;
    logic s4;
    logic s5;
    logic s6;
    logic s7;
    logic s8;
    a = '0;
    s0 = 1'b0;
    s1 = 1'b0;
    s2 = 1'b0;
    s3 = 1'b0;
    s4 = 1'b0;
    s5 = 1'b0;
    s6 = 1'b0;
    s7 = 1'b0;
    s8 = 1'b0;
    tr = rt_q;
    // gain factor
    a = clampv(mulsh(sx(coef.temp_gain_curv_coef), tr, SH21), LIM_LO, LIM_HI, s0); // RQ14
    a = clampv(a + (sx(coef.tcg) <<< 2), LIM_LO, LIM_HI, s1); // RQ14
    a = clampv(mulsh(tr, a, SH23), LIM_LO, LIM_HI, s2); // RQ14
    k1_d = clampv(ONE23 + a, LIM_LO, LIM_HI, s3); // RQ14
    // offset term
    a = clampv(mulsh(sx(coef.temp_offset_curv_coef), tr, SH21), LIM_LO, LIM_HI, s4); // RQ15
    a = clampv(a + (sx(coef.tco) <<< 2), LIM_LO, LIM_HI, s5); // RQ15
    a = clampv(mulsh(tr, a, SH23), LIM_LO, LIM_HI, s6); // RQ15
    a = clampv(rs_q + a, LIM_LO, LIM_HI, s7); // RQ15
    k2_d = clampv((sx(coef.offset_s) <<< 2) + a, LIM_LO, LIM_HI, s8); // RQ15
    sat_k = s0 | s1 | s2 | s3 | s4 | s5 | s6 | s7 | s8; // RQ10
  end

  always_comb begin
    logic signed [W-1:0] b;
    logic t0;
    logic t1;
    logic t2;
    b = '0;
    t0 = 1'b0;
    t1 = 1'b0;
    t2 = 1'b0;
    b = clampv(mulsh(k1_q, k2_q, SH23), LIM_LO, LIM_HI, t0); // RQ16
    b = clampv(mulsh(sx(coef.gain_s), b, SH21), LIM_LO, LIM_HI, t1); // RQ16
    zsp_d = clampv(b + ONE23, 48'sd0, ZSP_HI, t2); // RQ16
    sat_z = t0 | t1 | t2; // RQ10
  end

  always_comb begin
    logic signed [W-1:0] c;
    logic signed [W-1:0] zin;
    logic u0;
    logic u1;
    logic u2;
    c = '0;
    zin = '0;
    u0 = 1'b0;
    u1 = 1'b0;
    u2 = 1'b0;
    // s-shape uses magnitude of zsp; since zsp is clamped non-negative both coincide here
    zin = (zsp_q < 0) ? -zsp_q : zsp_q;
    c = clampv(mulsh(sx(coef.sensor_curv_coef), zin, SH21), LIM_LO, LIM_HI, u0); // RQ17
    c = clampv(c + ONE23, LIM_LO, LIM_HI, u1); // RQ17
    c = mulsh(zsp_q, c, SH23);
    if (coef.nonlinearity_shape_select) begin
      c = c + ONE23; // RQ11
    end
    out_d = clampv(c + sx(coef.sens_shift), 48'sd0, OUT_HI, u2); // RQ17 RQ12
    sat_o = u0 | u1 | u2; // RQ10
  end

  // ==========================================================
  // sequencing and result latch
  always_ff @(posedge mclk) begin
    if (rst_int) begin
      state_q <= ST_IDLE;
      k1_q <= '0;
      k2_q <= '0;
      zsp_q <= '0;
      rs_q <= '0;
      rt_q <= '0;
      sat_q <= 1'b0;
      result <= '0;
      result_valid <= 1'b0;
    end else begin
      result_valid <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (take && is_meas) begin
            state_q <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (conv_done) begin
            rs_q <= sx(raw_sensor); // RQ13
            rt_q <= sx(raw_temp); // RQ13
            sat_q <= 1'b0;
            // raw, temperature and uncorrected alternate results skip the math
            if (corr_q && !temp_q && !(alt_active && coef.alt_bypass)) begin
              state_q <= ST_K;
            end else begin
              result.value <= temp_q ? raw_temp : raw_sensor; // RQ8
              result.status <= 8'h00;
              state_q <= ST_DONE;
            end
          end
        end
        ST_K: begin
          k1_q <= k1_d; // RQ20
          k2_q <= k2_d;
          sat_q <= sat_k;
          state_q <= ST_ZSP;
        end
        ST_ZSP: begin
          zsp_q <= zsp_d; // RQ20
          sat_q <= sat_q | sat_z;
          state_q <= ST_OUT;
        end
        ST_OUT: begin
          result.value <= out_d[23:0]; // RQ12
          result.status <= 8'h00;
          result.status[STAT_SAT_BIT] <= sat_q | sat_o; // RQ9
          state_q <= ST_DONE;
        end
        ST_DONE: begin
          result_valid <= 1'b1; // RQ20
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end
endmodule : scm_core

// file: pkg/scm_pkg.sv
// package: constants and types for the sensor correction datapath
package scm_pkg;
  // command codes
  localparam logic [7:0] CMD_RAW_S_STORED = 8'hA2;
  localparam logic [7:0] CMD_RAW_S_USER = 8'hA3;
  localparam logic [7:0] CMD_RAW_T_STORED = 8'hA6;
  localparam logic [7:0] CMD_RAW_T_USER = 8'hA7;
  localparam logic [7:0] CMD_CORR_FIRST = 8'hAA;
  localparam logic [7:0] CMD_CORR_LAST = 8'hAF;
  localparam logic [7:0] CMD_SEL_PRIMARY = 8'hB0;
  localparam logic [7:0] CMD_SEL_ALT = 8'hB1;
  // memory addresses of the setup words
  localparam logic [7:0] ADDR_PRIMARY_SETUP = 8'h12;
  localparam logic [7:0] ADDR_ALT_SETUP = 8'h16;
  // host-supplied temperature setup ignores bits 15:12
  localparam logic [15:0] TEMP_SETUP_MASK = 16'h0FFF;
  // arithmetic limits
  localparam int W = 48;
  localparam logic signed [W-1:0] LIM_LO = -(48'sd1 <<< 25);
  localparam logic signed [W-1:0] LIM_HI = (48'sd1 <<< 25) - 48'sd1;
  localparam logic signed [W-1:0] ZSP_HI = (48'sd1 <<< 25) - 48'sd1;
  localparam logic signed [W-1:0] OUT_HI = (48'sd1 <<< 24) - 48'sd1;
  localparam logic signed [W-1:0] ONE23 = 48'sd1 <<< 23;
  localparam int SH21 = 21;
  localparam int SH23 = 23;
  localparam int STAT_SAT_BIT = 0;

  typedef struct packed {
    logic signed [23:0] gain_s;
    logic signed [23:0] offset_s;
    logic signed [23:0] tcg;
    logic signed [23:0] tco;
    logic signed [23:0] temp_gain_curv_coef;
    logic signed [23:0] temp_offset_curv_coef;
    logic signed [23:0] sensor_curv_coef;
    logic signed [23:0] sens_shift;
    logic nonlinearity_shape_select;
    logic alt_bypass;
  } scm_coef_t;

  typedef struct packed {
    logic [7:0] status;
    logic [23:0] value;
  } scm_result_t;
endpackage : scm_pkg

// file: tb/scm_chk_assertions.sv
// checker: assertions on the scm_core ports
`timescale 1ns/10ps
module scm_chk
  import scm_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic conv_done,
  input wire logic conv_is_temp,
  input wire logic conv_start,
  input wire logic alt_active,
  input wire logic result_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_data,
  input wire logic [15:0] primary_setup_word,
  input wire logic [15:0] temp_factory_setup,
  input wire logic [15:0] conv_setup,
  input wire scm_coef_t coef,
  input wire logic signed [23:0] raw_sensor,
  input wire logic signed [23:0] raw_temp,
  input wire scm_result_t result
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  // ==========
  // helper: kind of request in flight
  logic tk;
  logic [1:0] kind_q;
  logic [23:0] cap_q;
  assign tk = cmd_valid && cmd_ready;
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      kind_q <= 2'h0;
    end else if (tk && cmd_code inside {CMD_RAW_S_STORED, CMD_RAW_S_USER, CMD_RAW_T_STORED, CMD_RAW_T_USER}) begin
      kind_q <= 2'h1;
    end else if (tk && cmd_code inside {[CMD_CORR_FIRST:CMD_CORR_LAST]}) begin
      kind_q <= (alt_active && coef.alt_bypass) ? 2'h1 : 2'h2;
    end
  end
  // raw lines are only meaningful on the done pulse
  always_ff @(posedge mclk) begin
    if (conv_done) begin
      cap_q <= conv_is_temp ? raw_temp : raw_sensor;
    end
  end
  // ==========
  // assertions
  AST_A2: assert property (tk && cmd_code == CMD_RAW_S_STORED |=>
    conv_start && conv_setup == primary_setup_word) else $error("stored sensor setup wrong");
  AST_A3: assert property (tk && cmd_code == CMD_RAW_S_USER |=>
    !conv_is_temp && conv_setup == $past(cmd_data)) else $error("user sensor setup wrong");
  AST_A7: assert property (tk && cmd_code == CMD_RAW_T_USER |=>
    conv_is_temp && conv_setup == ($past(cmd_data) & TEMP_SETUP_MASK)) else $error("user temp setup wrong");
  AST_A6: assert property (tk && cmd_code == CMD_RAW_T_STORED |=>
    conv_is_temp && conv_setup == temp_factory_setup) else $error("factory temp setup wrong");
  AST_ALT: assert property (tk && cmd_code == CMD_SEL_ALT |-> ##[1:2] alt_active)
    else $error("alternate setup not active");
  AST_RST: assert property ($rose(rstn) |-> !alt_active)
    else $error("alternate setup survives reset");
  AST_RAW: assert property (conv_done && kind_q == 2'h1 |->
    ##2 result_valid && result.value == cap_q) else $error("raw pass wrong");
  AST_COR: assert property (conv_done && kind_q == 2'h2 |->
    !result_valid [*5] ##1 result_valid) else $error("corrected latency wrong");
  cover property (tk && cmd_code == CMD_SEL_ALT);
  cover property (result_valid && result.status[STAT_SAT_BIT]);
  cover property (conv_done && kind_q == 2'h2);
endmodule : scm_chk

// file: tb/scm_conv_model.sv
// converter model answering measurement starts
`timescale 1ns/10ps
module scm_conv_model (
  input wire logic mclk,
  input wire logic conv_start,
  input wire logic signed [23:0] s_val,
  input wire logic signed [23:0] t_val,
  output logic conv_done = 1'b0,
  output logic signed [23:0] raw_sensor,
  output logic signed [23:0] raw_temp
);
  int cnt = 0;
  int dly = 3;
  always @(posedge mclk) begin
    conv_done <= 1'b0;
    if (conv_start) begin
      cnt <= dly;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      conv_done <= (cnt == 1);
    end
  end
  // stale values inverted so a late sample shows
  assign raw_sensor = conv_done ? s_val : ~s_val;
  assign raw_temp = conv_done ? t_val : ~t_val;
endmodule : scm_conv_model

// file: tb/tb_top.sv
// bench for the sensor correction datapath
`timescale 1ns/10ps
module tb_top;
  import scm_pkg::*;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic pin_n = 1'b1;
  logic cmd_valid = 1'b0;
  logic [7:0] cmd_code = 8'h00;
  logic [15:0] cmd_data = 16'h0000;
  logic signed [23:0] s_val = 24'h012345;
  logic signed [23:0] t_val = 24'hFF5433;
  scm_coef_t coef = '0;
  logic cmd_ready, conv_start, conv_is_temp, conv_done, alt_active, result_valid;
  logic [15:0] conv_setup;
  logic signed [23:0] raw_sensor, raw_temp;
  scm_result_t result;
  int errors = 0;
  int num_checks = 0;
  int n;
  // calibration points: three sensor values, three temperatures
  logic signed [23:0] cal_s [3] = '{24'h012345, 24'h07FFFF, 24'hF80001};
  logic signed [23:0] cal_t [3] = '{24'hFF5433, 24'h000100, 24'h07FFFF};
  logic [63:0] rows [4] = '{64'hA2_0000_1111_012345, 64'hA3_BEEF_BEEF_012345,
    64'hA6_0000_3333_FF5433, 64'hA7_FFFF_0FFF_FF5433};
  always #5 mclk = ~mclk;
  scm_core uut (.mclk(mclk), .rstn(rstn), .external_reset_pin_n(pin_n), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_data(cmd_data), .cmd_ready(cmd_ready), .primary_setup_word(16'h1111),
    .alternate_setup_word(16'h2222), .temp_factory_setup(16'h3333), .coef(coef), .conv_start(conv_start),
    .conv_is_temp(conv_is_temp), .conv_setup(conv_setup), .conv_done(conv_done), .raw_sensor(raw_sensor),
    .raw_temp(raw_temp), .alt_active(alt_active), .result(result), .result_valid(result_valid));
  scm_conv_model m (.mclk(mclk), .conv_start(conv_start), .s_val(s_val), .t_val(t_val),
    .conv_done(conv_done), .raw_sensor(raw_sensor), .raw_temp(raw_temp));
  // ==========
  // tasks
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up
  task automatic tmo(input int lim);
    if (n >= lim) begin
      errors++;
      wrap_up();
    end
  endtask : tmo
  task automatic send(input logic [7:0] c, input logic [15:0] d);
    @(posedge mclk);
    cmd_code <= c;
    cmd_data <= d;
    cmd_valid <= 1'b1;
    n = 0;
    do @(posedge mclk); while (!cmd_ready && ++n < 50);
    tmo(50);
    cmd_valid <= 1'b0;
  endtask : send
  task automatic run(input logic [7:0] c, input logic [15:0] d, input logic [15:0] su, input logic [23:0] v,
      input logic sat);
    send(c, d);
    n = 0;
    do @(posedge mclk); while (!result_valid && ++n < 200);
    tmo(200);
    chk("setup", {8'h00, su}, {8'h00, conv_setup});
    chk("value", v, result.value);
    chk("sat", {23'h0, sat}, {23'h0, result.status[STAT_SAT_BIT]});
  endtask : run
  // ==========
  // sequence; post offsets stay zero as in first calibration
  initial begin
    coef.gain_s <= 24'h200000;
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    chk("alt_rst", 24'h0, {23'h0, alt_active});
    foreach (rows[i]) run(rows[i][63:56], rows[i][55:40], rows[i][39:24], rows[i][23:0], 1'b0);
    // seven raw pairs over three temperatures; last pair leaves sensor at 012345
    for (int k = 0; k < 7; k++) begin
      s_val <= cal_s[k % 3];
      t_val <= cal_t[k / 3];
      run(CMD_RAW_S_STORED, 16'h0000, 16'h1111, cal_s[k % 3], 1'b0);
      run(CMD_RAW_T_STORED, 16'h0000, 16'h3333, cal_t[k / 3], 1'b0);
    end
    for (int c = 8'hAA; c <= 8'hAF; c++) run(c[7:0], 16'h0000, 16'h1111, 24'h812345, 1'b0);
    m.dly = 25;
    coef.gain_s <= 24'h7FFFFF;
    coef.offset_s <= 24'h07FFFF;
    s_val <= 24'h07FFFF;
    run(CMD_CORR_FIRST, 16'h0000, 16'h1111, 24'hFFFFFF, 1'b1);
    coef.offset_s <= 24'hF80001;
    s_val <= 24'hF80001;
    run(CMD_CORR_LAST, 16'h0000, 16'h1111, 24'h000000, 1'b1);
    m.dly = 3;
    coef.gain_s <= 24'h200000;
    coef.offset_s <= 24'h000000;
    coef.nonlinearity_shape_select <= 1'b1;
    run(CMD_CORR_FIRST, 16'h0000, 16'h1111, 24'hF80001, 1'b0);
    coef.alt_bypass <= 1'b1;
    send(CMD_SEL_ALT, 16'h0000);
    repeat (2) @(posedge mclk);
    chk("alt_on", 24'h1, {23'h0, alt_active});
    run(CMD_CORR_FIRST, 16'h0000, 16'h2222, 24'hF80001, 1'b0);
    run(CMD_RAW_S_STORED, 16'h0000, 16'h1111, 24'hF80001, 1'b0);
    pin_n <= 1'b0;
    repeat (4) @(posedge mclk);
    pin_n <= 1'b1;
    repeat (4) @(posedge mclk);
    chk("alt_pin", 24'h0, {23'h0, alt_active});
    send(CMD_SEL_ALT, 16'h0000);
    send(CMD_SEL_PRIMARY, 16'h0000);
    repeat (2) @(posedge mclk);
    chk("alt_off", 24'h0, {23'h0, alt_active});
    wrap_up();
  end
endmodule : tb_top
bind scm_core scm_chk u_chk (.*);
